// *** psm_defs.vh ***
// Purpose: offsets, field positions and reset values of the monitor register bank
// Assumes: 3-bit register index from the serial engine
// Notes: definitions only
`ifndef PSM_DEFS_VH
`define PSM_DEFS_VH
`define ADDR_W 3
`define OFF_ALERT_EN 3'h1
`define OFF_LIVE 3'h2
`define OFF_FAULT 3'h3
`define OFF_SENSE 3'h4
`define OFF_SOURCE 3'h5
`define OFF_AUX 3'h6
`define BIT_GPIO_OUT 6
`define BIT_SHORT 5
`define BIT_EN_CHG 4
`define BIT_PBAD 3
`define BIT_OC 2
`define BIT_UNDERVOLT 1
`define BIT_OVERVOLT 0
`define BIT_FET_ON 7
`define BIT_GPIO_IN 6
`define ALERT_EN_RST 8'h00
`define FAULT_RST 8'h00
`define RESULT_RST 8'h00
`define ALERT_WMASK 8'h7F
`define FAULT_WMASK 8'h3F
`endif

// *** result_store.v ***
// Purpose: three 8-bit converter result words, registered read
// Assumes: converter and host writes never fall in the same cycle
// Notes: converter write wins if they do
`timescale 1ns/100ps
module result_store #(
    parameter DW = 8
) (
    input wire clk_sys_in,
    input wire reset_n_in,
    input wire [1:0] wr_idx_in,
    input wire wr_en_in,
    input wire [DW-1:0] wr_data_in,
    input wire [1:0] rd_idx_in,
    output reg [DW-1:0] rd_data_out
);
reg [DW-1:0] mem_q [0:2];
integer i;
always @(posedge clk_sys_in)
begin
    if (!reset_n_in)
    begin
        for (i = 0; i < 3; i = i + 1)
            mem_q[i] <= {DW{1'b0}};
        rd_data_out <= {DW{1'b0}};
    end
    else
    begin
        if (wr_en_in && wr_idx_in != 2'h3)
            mem_q[wr_idx_in] <= wr_data_in;
        rd_data_out <= (rd_idx_in == 2'h3) ? {DW{1'b0}} : mem_q[rd_idx_in];
    end
end
endmodule

// *** fault_latch.v ***
// Purpose: sticky fault flags with write-zero clear
// Assumes: events are one-cycle or level requests
// Notes: a set in the clearing cycle wins
`timescale 1ns/100ps
module fault_latch #(
    parameter W = 6
) (
    input wire clk_sys_in,
    input wire reset_n_in,
    input wire [W-1:0] set_in,
    input wire wr_in,
    input wire [W-1:0] wr_data_in,
    output reg [W-1:0] flags_out,
    output wire [W-1:0] rise_out
);
reg [W-1:0] flags_d;
always @*
begin
    flags_d = flags_out;
    if (wr_in)
        flags_d = flags_out & wr_data_in;
    flags_d = flags_d | set_in;
end
assign rise_out = flags_d & ~flags_out;
always @(posedge clk_sys_in)
begin
    if (!reset_n_in)
        flags_out <= {W{1'b0}};
    else
        flags_out <= flags_d;
end
endmodule

// *** power_switch_monitor_regs.v ***
// Purpose: register bank of a board insertion power controller
// Assumes: serial engine gives index, write strobe, data; inputs synchronous
// Notes: alert is a level until no enabled fault flag remains set
// Function
// - gpio output bit drives pin when output
// - short alert enable, reset disabled
// - enable-pin change alert enable
// - power-bad alert enable
// - overcurrent alert enable
// - undervoltage and overvoltage alert enables
// - status bit seven shows transistor on
// - status bit six shows gpio level
// - live short bit: sense high, transistor off
// - status bit four is enable pin inverted
// - status bit three while power-good low
// - status bit two on cool-down overcurrent
// - status bit one while undervoltage low
// - status bit zero while overvoltage high
// - latch short fault bit five
// - latch enable-pin change fault bit four
// - latch power-bad fault bit three
// - latch overcurrent fault bit two
// - latch undervoltage and overvoltage faults
// - hold 8-bit sense result
// - hold 8-bit source result
// - hold 8-bit auxiliary result
`timescale 1ns/100ps
`include "psm_defs.vh"
module power_switch_monitor_regs #(
    parameter DW = 8
) (
    input wire clk_sys_in,
    input wire reset_n_in,
    input wire [2:0] reg_addr_in,
    input wire reg_wr_in,
    input wire [DW-1:0] reg_wdata_in,
    output reg [DW-1:0] reg_rdata_out,
    input wire fet_on_in,
    input wire gpio_pin_in,
    input wire gpio_is_output_in,
    output wire gpio_out,
    output wire gpio_oe_out,
    input wire sense_over_thresh_in,
    input wire enable_pin_in,
    input wire power_good_sense_input,
    input wire oc_cooldown_in,
    input wire oc_fault_in,
    input wire undervoltage_input,
    input wire overvoltage_input,
    input wire conv_wr_in,
    input wire [1:0] conv_sel_in,
    input wire [DW-1:0] conv_data_in,
    output reg alert_out
);
reg [7:0] alert_en_q;
reg enable_prev_q;
reg enable_seen_q;
reg [7:0] live_q;
wire [7:0] live_d;
wire [5:0] fault_set;
wire [5:0] fault_flags;
wire [5:0] fault_rise;
wire [DW-1:0] res_rdata;
wire host_res_wr;
wire [1:0] res_wr_idx;
wire [1:0] res_rd_idx;
reg [2:0] addr_q;
function [1:0] res_index;
    input [2:0] a;
    begin
        case (a)
            `OFF_SENSE: res_index = 2'h0;
            `OFF_SOURCE: res_index = 2'h1;
            `OFF_AUX: res_index = 2'h2;
            default: res_index = 2'h3;
        endcase
    end
endfunction
always @(posedge clk_sys_in)
begin
    if (!reset_n_in)
    begin
        alert_en_q <= `ALERT_EN_RST;
    end
    else if (reg_wr_in && reg_addr_in == `OFF_ALERT_EN)
    begin
        alert_en_q <= reg_wdata_in[7:0] & `ALERT_WMASK;
    end
end
assign gpio_out = alert_en_q[`BIT_GPIO_OUT];
assign gpio_oe_out = gpio_is_output_in;
assign live_d[`BIT_FET_ON] = fet_on_in;
assign live_d[`BIT_GPIO_IN] = gpio_pin_in;
assign live_d[`BIT_SHORT] = sense_over_thresh_in & ~fet_on_in;
assign live_d[`BIT_EN_CHG] = ~enable_pin_in;
assign live_d[`BIT_PBAD] = ~power_good_sense_input;
assign live_d[`BIT_OC] = oc_cooldown_in;
assign live_d[`BIT_UNDERVOLT] = ~undervoltage_input;
assign live_d[`BIT_OVERVOLT] = overvoltage_input;
// first sample after reset only primes the edge detector
always @(posedge clk_sys_in)
begin
    if (!reset_n_in)
    begin
        live_q <= 8'h00;
        enable_prev_q <= 1'b0;
        enable_seen_q <= 1'b0;
    end
    else
    begin
        live_q <= live_d;
        enable_prev_q <= enable_pin_in;
        enable_seen_q <= 1'b1;
    end
end
assign fault_set[`BIT_SHORT] = live_d[`BIT_SHORT];
assign fault_set[`BIT_EN_CHG] = enable_seen_q & (enable_pin_in ^ enable_prev_q);
assign fault_set[`BIT_PBAD] = live_d[`BIT_PBAD];
assign fault_set[`BIT_OC] = oc_fault_in;
assign fault_set[`BIT_UNDERVOLT] = live_d[`BIT_UNDERVOLT];
assign fault_set[`BIT_OVERVOLT] = live_d[`BIT_OVERVOLT];
fault_latch #(
    .W(6)
) u_fault (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .set_in(fault_set),
    .wr_in(reg_wr_in && reg_addr_in == `OFF_FAULT),
    .wr_data_in(reg_wdata_in[5:0]),
    .flags_out(fault_flags),
    .rise_out(fault_rise)
);
// alert stays until no enabled fault flag is set; level conditions keep their flags set
always @(posedge clk_sys_in)
begin
    if (!reset_n_in)
        alert_out <= 1'b0;
    else if (|(fault_rise & alert_en_q[5:0]))
        alert_out <= 1'b1;
    else if (~|(fault_flags & alert_en_q[5:0]))
        alert_out <= 1'b0;
end
// converter results take priority over a host write in the same cycle
assign host_res_wr = reg_wr_in && res_index(reg_addr_in) != 2'h3;
assign res_wr_idx = conv_wr_in ? conv_sel_in : res_index(reg_addr_in);
assign res_rd_idx = res_index(reg_addr_in);
result_store #(
    .DW(DW)
) u_res (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .wr_idx_in(res_wr_idx),
    .wr_en_in(conv_wr_in | host_res_wr),
    .wr_data_in(conv_wr_in ? conv_data_in : reg_wdata_in),
    .rd_idx_in(res_rd_idx),
    .rd_data_out(res_rdata)
);
always @(posedge clk_sys_in)
begin
    if (!reset_n_in)
        addr_q <= 3'h0;
    else
        addr_q <= reg_addr_in;
end
// read data valid one cycle after the address is presented
// clear first so the narrow registers zero-extend without empty replications
always @*
begin
    reg_rdata_out = {DW{1'b0}};
    case (addr_q)
        `OFF_ALERT_EN: reg_rdata_out[7:0] = alert_en_q;
        `OFF_LIVE: reg_rdata_out[7:0] = live_q;
        `OFF_FAULT: reg_rdata_out[5:0] = fault_flags;
        `OFF_SENSE: reg_rdata_out = res_rdata;
        `OFF_SOURCE: reg_rdata_out = res_rdata;
        `OFF_AUX: reg_rdata_out = res_rdata;
        default: reg_rdata_out = {DW{1'b0}};
    endcase
end
endmodule

// *** psm_sva.sv ***
// Purpose: port checks of the monitor register bank
// Assumes: inputs change just after a clock edge
// Notes: flags checked only over steady inputs
`timescale 1ns/100ps
module psm_sva (
    input wire clk_sys_in,
    input wire reset_n_in,
    input wire reg_wr_in,
    input wire conv_wr_in,
    input wire gpio_is_output_in,
    input wire fet_on_in,
    input wire gpio_pin_in,
    input wire sense_over_thresh_in,
    input wire enable_pin_in,
    input wire oc_cooldown_in,
    input wire power_good_sense_input,
    input wire undervoltage_input,
    input wire overvoltage_input,
    input wire [2:0] reg_addr_in,
    input wire [1:0] conv_sel_in,
    input wire [7:0] reg_wdata_in,
    input wire [7:0] reg_rdata_out,
    input wire [7:0] conv_data_in,
    input wire gpio_out,
    input wire gpio_oe_out,
    input wire alert_out
);
    wire wd6 = reg_wdata_in[6];
    wire [7:0] live = {fet_on_in, gpio_pin_in, sense_over_thresh_in & ~fet_on_in, ~enable_pin_in,
        ~power_good_sense_input, oc_cooldown_in, ~undervoltage_input, overvoltage_input};
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_conv_sense;
        conv_wr_in && conv_sel_in == 2'h0 && reg_addr_in == 3'h4;
    endsequence
    sequence s_hold_sense;
        reg_addr_in == 3'h4 && !conv_wr_in && !reg_wr_in;
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0)
        !reset_n_in |=> !alert_out && !gpio_out) else $error("alert or gpio high after reset");
    a_oe_follow: assert property (gpio_oe_out == gpio_is_output_in)
        else $error("gpio enable wrong");
    a_gpio_write: assert property (reg_wr_in && reg_addr_in == 3'h1
        |=> gpio_out == $past(wd6)) else $error("gpio bit not stored");
    a_gpio_hold: assert property (!(reg_wr_in && reg_addr_in == 3'h1)
        |=> $stable(gpio_out)) else $error("gpio bit moved");
    a_unmapped_zero: assert property (reg_addr_in == 3'h0 || reg_addr_in == 3'h7
        |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
    // status is sampled, so the read shows the inputs of the address cycle
    a_live_flags: assert property ((reg_addr_in == 3'h2 && $stable(live))[*3]
        |=> reg_rdata_out == $past(live)) else $error("status flags wrong");
    a_fault_level: assert property ((reg_addr_in == 3'h3 && overvoltage_input
        && !undervoltage_input)[*3] |-> ##1 reg_rdata_out[1:0] == 2'h3) else $error("fault lost");
    a_sense_store: assert property (s_conv_sense ##1 s_hold_sense
        |=> reg_rdata_out == $past(conv_data_in, 2)) else $error("sense result not held");
endmodule
bind power_switch_monitor_regs psm_sva psm_sva_i (.*);

// *** reg_host.sv ***
// Purpose: serial host stand-in for register reads and writes
// Assumes: one access at a time
// Notes: read data taken two edges after the index is set
`timescale 1ns/100ps
module reg_host (
    input wire clk_sys_in,
    input wire [7:0] rdata_in,
    output reg [2:0] addr_out = 3'h0,
    output reg wr_out = 1'b0,
    output reg [7:0] wdata_out = 8'h00
);
    task wr(input [2:0] a, input [7:0] d);
    begin
        @(posedge clk_sys_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_sys_in);
        wr_out <= 1'b0;
        wdata_out <= ~d; // stale data inverted so a late sample shows
    end
    endtask
    task rd(input [2:0] a, output [7:0] d);
    begin
        @(posedge clk_sys_in);
        addr_out <= a;
        repeat (2) @(posedge clk_sys_in);
        #1 d = rdata_in;
    end
    endtask
endmodule

// *** tb.sv ***
// Purpose: register bank test
// Assumes: live inputs steady two edges before a read
// Notes: expected values worked out by hand
`timescale 1ns/100ps
module tb;
    reg clk_sys_in = 1'b0;
    reg reset_n_in = 1'b0;
    reg [9:0] inp = 10'h065;
    reg conv_wr_in = 1'b0;
    reg [1:0] conv_sel_in = 2'h0;
    reg [7:0] conv_data_in = 8'h00;
    reg [7:0] d;
    integer i, err_total = 0, tests_run = 0;
    wire [2:0] reg_addr_in;
    wire reg_wr_in, gpio_out, gpio_oe_out, alert_out, fet_on_in, gpio_pin_in, sense_over_thresh_in;
    wire enable_pin_in, power_good_sense_input, oc_cooldown_in, oc_fault_in;
    wire undervoltage_input, overvoltage_input, gpio_is_output_in;
    wire [7:0] reg_wdata_in, reg_rdata_out;
    assign {fet_on_in, gpio_pin_in, sense_over_thresh_in, enable_pin_in, power_good_sense_input,
        oc_cooldown_in, oc_fault_in, undervoltage_input, overvoltage_input, gpio_is_output_in} = inp;
    always #2 clk_sys_in = ~clk_sys_in;
    power_switch_monitor_regs power_switch_monitor_regs_i (.*);
    reg_host host_i (.clk_sys_in(clk_sys_in), .rdata_in(reg_rdata_out), .addr_out(reg_addr_in),
        .wr_out(reg_wr_in), .wdata_out(reg_wdata_in));
    task chk(input [7:0] seen, input [7:0] exp);
    begin
        tests_run = tests_run + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    task setin(input [9:0] p);
    begin
        @(posedge clk_sys_in) inp <= p;
        repeat (2) @(posedge clk_sys_in);
    end
    endtask
    task end_sim;
    begin
        $display("checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    initial
    begin
        #20000 err_total = err_total + 1;
        end_sim;
    end
    initial
    begin
        repeat (20) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        for (i = 0; i < 8; i = i + 1)
        begin
            host_i.rd(i[2:0], d);
            chk(d, 8'h00);
        end
        $display("done: reset values");
        host_i.wr(3'h1, 8'hFF);
        host_i.rd(3'h1, d);
        chk(d, 8'h7F);
        chk({7'h00, gpio_out}, 8'h01);
        setin(10'h39B);
        host_i.rd(3'h2, d);
        chk(d, 8'hDF);
        host_i.rd(3'h3, d);
        chk(d, 8'h1F);
        chk({7'h00, alert_out}, 8'h01);
        setin(10'h0E4);
        host_i.rd(3'h2, d);
        chk(d, 8'h20);
        host_i.wr(3'h3, 8'h00);
        host_i.rd(3'h3, d);
        chk(d, 8'h20);
        chk({7'h00, alert_out}, 8'h01);
        setin(10'h064);
        host_i.wr(3'h3, 8'h00);
        host_i.rd(3'h3, d);
        chk(d, 8'h00);
        chk({7'h00, alert_out}, 8'h00);
        $display("done: flags");
        host_i.wr(3'h1, 8'h00);
        setin(10'h066);
        host_i.wr(3'h2, 8'hFF);
        host_i.rd(3'h2, d);
        chk(d, 8'h01);
        host_i.rd(3'h3, d);
        chk(d, 8'h01);
        chk({6'h00, gpio_out, alert_out}, 8'h00);
        $display("done: masked alert");
        host_i.wr(3'h1, 8'h40);
        @(posedge clk_sys_in) reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        host_i.rd(3'h1, d);
        chk(d, 8'h00);
        chk({7'h00, gpio_out}, 8'h00);
        host_i.rd(3'h3, d);
        chk(d, 8'h01);
        $display("done: mid-run reset");
        for (i = 0; i < 3; i = i + 1)
        begin
            host_i.rd(3'h4 + i[2:0], d);
            @(posedge clk_sys_in);
            conv_wr_in <= 1'b1;
            conv_sel_in <= i[1:0];
            conv_data_in <= 8'hA0 + i[7:0];
            @(posedge clk_sys_in);
            conv_wr_in <= 1'b0;
            host_i.rd(3'h4 + i[2:0], d);
            chk(d, 8'hA0 + i[7:0]);
        end
        host_i.wr(3'h5, 8'h5A);
        host_i.rd(3'h5, d);
        chk(d, 8'h5A);
        $display("done: results");
        end_sim;
    end
endmodule
